// ---- gdmd_top.sv ----
// Chosen here: the Avalon-MM slave port and the address map.
`include "gdmd_regs.svh"

module gdmd_top #(
  parameter int unsigned READY_CYCLES = `GDMD_READY_CYCLES,
  parameter int unsigned DT_WIDTH     = 8
) (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  input  wire logic [4:0]                          avs_address,
  input  wire logic [3:0]                          avs_byteenable,
  input  wire logic                                avs_read,
  input  wire logic                                avs_write,
  input  wire logic [31:0]                         avs_writedata,
  output logic      [31:0]                         avs_readdata,
  output logic                                     avs_waitrequest,
  input  wire logic [2:0]                          high_side_ctrl_in,
  input  wire logic [2:0]                          low_side_ctrl_in,
  input  wire logic                                bus_variant_strap,
  input  wire logic [2:0]                          scheme_strap,
  input  wire logic [gdmd_pkg::FAULT_EXT_W-1:0]    fault_in,
  output logic      [2:0]                          high_gate_out,
  output logic      [2:0]                          low_gate_out,
  output logic                                     fault_indicator_n,
  output logic                                     irq
);
  import gdmd_pkg::*;

  localparam int unsigned RCW = $clog2(READY_CYCLES + 1);

  logic [2:0]             hs_m_q, hs_s_q, ls_m_q, ls_s_q;
  logic [FAULT_EXT_W-1:0] flt_m_q, flt_s_q;
  logic                   var_m_q, var_s_q;
  logic [2:0]             strap_m_q, strap_s_q;
  logic                   strap_done_q, bus_var_q;
  logic [2:0]             strap_sel_q;
  logic [RCW-1:0]         rdy_cnt_q;
  logic                   ready_q;
  gdmd_bus_t              bus_st_q;
  logic [31:0]            rd_d, rdata_q;
  logic                   wait_q;
  logic [2:0]             sel_q;
  logic                   drive_en_q;
  logic [FAULT_W-1:0]     status_q, mask_q, fault_set;
  logic [DT_WIDTH-1:0]    dead_q;
  logic                   irq_q, fault_n_q;
  gdmd_scheme_t           active_q, cand;
  logic                   all_low, mode_bad, kill, wr_hit;
  logic [31:0]            be32, wbits;
  logic [2:0]             want_h, want_l, indep;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Input resynchronisers
  // two-flop resample
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hs_m_q    <= 3'h0;
      hs_s_q    <= 3'h0;
      ls_m_q    <= 3'h0;
      ls_s_q    <= 3'h0;
      flt_m_q   <= '0;
      flt_s_q   <= '0;
      var_m_q   <= 1'b0;
      var_s_q   <= 1'b0;
      strap_m_q <= 3'h0;
      strap_s_q <= 3'h0;
    end else begin
      hs_m_q    <= high_side_ctrl_in;
      hs_s_q    <= hs_m_q;
      ls_m_q    <= low_side_ctrl_in;
      ls_s_q    <= ls_m_q;
      flt_m_q   <= fault_in;
      flt_s_q   <= flt_m_q;
      var_m_q   <= bus_variant_strap;
      var_s_q   <= var_m_q;
      strap_m_q <= scheme_strap;
      strap_s_q <= strap_m_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdy_cnt_q <= '0;
      ready_q   <= 1'b0;
    end else if (!ready_q) begin
      if (rdy_cnt_q == RCW'(READY_CYCLES - 1)) begin
        ready_q <= 1'b1;
      end else begin
        rdy_cnt_q <= rdy_cnt_q + RCW'(1);
      end
    end
  end

  // straps caught once at end of window
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      bus_var_q    <= 1'b0;
      strap_sel_q  <= 3'h0;
    end else if (!strap_done_q && rdy_cnt_q == RCW'(READY_CYCLES - 1)) begin
      strap_done_q <= 1'b1;
      bus_var_q    <= var_s_q;
      strap_sel_q  <= strap_s_q;
    end
  end

  // Avalon slave: one wait state, read data registered
  assign wr_hit = (bus_st_q == BUS_ACK) && avs_write;
  assign be32   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wbits  = avs_writedata & be32;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_st_q <= BUS_IDLE;
      wait_q   <= 1'b1;
      rdata_q  <= 32'h0000_0000;
    end else begin
      unique case (bus_st_q)
        BUS_IDLE: begin
          if ((avs_read || avs_write) && ready_q) begin
            bus_st_q <= BUS_ACK;
            wait_q   <= 1'b0;
            rdata_q  <= avs_read ? rd_d : 32'h0000_0000;
          end
        end
        BUS_ACK: begin
          bus_st_q <= BUS_IDLE;
          wait_q   <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    case (avs_address)
      `GDMD_OFS_CTRL: begin
        rd_d[`GDMD_CTRL_SEL_LSB +: 3] = sel_q;
        rd_d[`GDMD_CTRL_EN_BIT]       = drive_en_q;
      end
      `GDMD_OFS_STATUS: rd_d[FAULT_W-1:0] = status_q;
      `GDMD_OFS_MASK:   rd_d[FAULT_W-1:0] = mask_q;
      `GDMD_OFS_DEAD:   rd_d[DT_WIDTH-1:0] = dead_q;
      `GDMD_OFS_STATE: begin
        rd_d[2:0]                       = active_q;
        rd_d[`GDMD_STATE_GH_LSB +: 3]   = high_gate_out;
        rd_d[`GDMD_STATE_GL_LSB +: 3]   = low_gate_out;
        rd_d[`GDMD_STATE_VAR_BIT]       = bus_var_q;
        rd_d[`GDMD_STATE_RDY_BIT]       = ready_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_q      <= `GDMD_SEL_RST;
      drive_en_q <= 1'b0;
      mask_q     <= `GDMD_MASK_RST;
      dead_q     <= DT_WIDTH'(`GDMD_DEAD_CYCLES);
    end else if (wr_hit) begin
      if (avs_address == `GDMD_OFS_CTRL && avs_byteenable[0]) begin
        // selector writable on bus variant only
        if (bus_var_q) begin
          sel_q <= avs_writedata[`GDMD_CTRL_SEL_LSB +: 3];
        end
        drive_en_q <= avs_writedata[`GDMD_CTRL_EN_BIT];
      end
      if (avs_address == `GDMD_OFS_MASK) begin
        mask_q <= (mask_q & ~be32[FAULT_W-1:0]) | wbits[FAULT_W-1:0];
      end
      if (avs_address == `GDMD_OFS_DEAD && avs_byteenable[0]) begin
        dead_q <= avs_writedata[DT_WIDTH-1:0];
      end
    end
  end

  assign mode_bad = strap_done_q && !bus_var_q && (strap_sel_q == SCH_HB_AB_FC);

  always_comb begin
    fault_set                = '0;
    fault_set[FAULT_EXT_W-1:0] = flt_s_q;
    fault_set[FLT_MODE_BAD]  = mode_bad;
  end

  // Status: write one to clear, a live fault wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~((wr_hit && avs_address == `GDMD_OFS_STATUS) ?
                  wbits[FAULT_W-1:0] : {FAULT_W{1'b0}})) | fault_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q     <= 1'b0;
      fault_n_q <= 1'b1;
    end else begin
      irq_q     <= |(status_q & mask_q);
      // any fault pulls the pin low
      fault_n_q <= ~|status_q;
    end
  end

  assign avs_readdata      = rdata_q;
  assign avs_waitrequest   = wait_q;
  assign irq               = irq_q;
  assign fault_indicator_n = fault_n_q;

  // Scheme selection
  // eight codes from register, straps on other variant
  assign cand    = gdmd_scheme_t'(bus_var_q ? sel_q : strap_sel_q);
  assign all_low = ~|{hs_s_q, ls_s_q};

  // switch only while inputs resynchronised low
  // relies on host parking inputs low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_q <= SCH_SIX;
    end else if (all_low && strap_done_q && !mode_bad) begin
      active_q <= cand;
    end
  end

  function automatic logic [5:0] six_step(input logic [2:0] hall, input logic pwm,
                                          input logic dir, input logic brake_n);
    logic [2:0] h;
    logic [2:0] gh;
    logic [2:0] gl;
    // Stop and align codes read the same in both directions
    h  = (dir && hall != 3'b000 && hall != 3'b111) ? ~hall : hall;
    gh = 3'h0;
    gl = 3'h0;
    case (h)
      3'b111: begin gh = {2'b00, pwm};  gl = {2'b11, ~pwm}; end
      3'b110: begin gh = {1'b0, pwm, 1'b0}; gl = {1'b1, ~pwm, 1'b0}; end
      3'b100: begin gh = {2'b00, pwm};  gl = {2'b10, ~pwm}; end
      3'b101: begin gh = {2'b00, pwm};  gl = {2'b01, ~pwm}; end
      3'b001: begin gh = {pwm, 2'b00};  gl = {~pwm, 2'b10}; end
      3'b011: begin gh = {pwm, 2'b00};  gl = {~pwm, 2'b01}; end
      3'b010: begin gh = {1'b0, pwm, 1'b0}; gl = {1'b0, ~pwm, 1'b1}; end
      default: begin gh = 3'h0; gl = 3'h0; end
    endcase
    if (!brake_n) begin
      gh = 3'h0;
      gl = 3'h7;
    end
    return {gh, gl};
  endfunction

  // Input decode per scheme
  always_comb begin
    want_h = 3'h0;
    want_l = 3'h0;
    indep  = 3'h0;
    unique case (active_q)
      SCH_SIX: begin
        want_h = hs_s_q & ~ls_s_q;
        want_l = ls_s_q & ~hs_s_q;
      end
      SCH_THREE: begin
        want_h = ls_s_q & hs_s_q;
        want_l = ls_s_q & ~hs_s_q;
      end
      SCH_ONE: begin
        {want_h, want_l} = six_step({ls_s_q[0], hs_s_q[1], ls_s_q[1]}, hs_s_q[0],
                                    hs_s_q[2], ls_s_q[2]);
      end
      SCH_HB_ALL, SCH_HB_AB_FC, SCH_HB_BC_FA, SCH_HB_A_FBC, SCH_FET_ALL: begin
        unique case (active_q)
          SCH_HB_AB_FC: indep = 3'b100;
          SCH_HB_BC_FA: indep = 3'b001;
          SCH_HB_A_FBC: indep = 3'b110;
          SCH_FET_ALL:  indep = 3'b111;
          default:      indep = 3'b000;
        endcase
        want_h = (indep & hs_s_q) | (~indep & ls_s_q & hs_s_q);
        want_l = (indep & ls_s_q) | (~indep & ls_s_q & ~hs_s_q);
      end
    endcase
  end

  // gate-short, supply, pump, short to supply or ground, shutdown force gates off
  assign kill = !drive_en_q || !ready_q || mode_bad ||
                |(flt_s_q & FAULT_EXT_W'(`GDMD_KILL_MASK));

  for (genvar p = 0; p < 3; p++) begin : g_ph
    logic                gh_q, gl_q;
    logic [DT_WIDTH-1:0] cnt_q;

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        gh_q  <= 1'b0;
        gl_q  <= 1'b0;
        cnt_q <= '0;
      end else if (kill) begin
        gh_q  <= 1'b0;
        gl_q  <= 1'b0;
        cnt_q <= dead_q;
      end else if (indep[p]) begin
        gh_q  <= want_h[p];
        gl_q  <= want_l[p];
        cnt_q <= '0;
      end else if (gh_q && !want_h[p]) begin
        gh_q  <= 1'b0;
        cnt_q <= dead_q;
      end else if (gl_q && !want_l[p]) begin
        gl_q  <= 1'b0;
        cnt_q <= dead_q;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - DT_WIDTH'(1);
      end else if (want_h[p] && !gl_q) begin
        gh_q <= 1'b1;
      end else if (want_l[p] && !gh_q) begin
        gl_q <= 1'b1;
      end
    end

    assign high_gate_out[p] = gh_q;
    assign low_gate_out[p]  = gl_q;

    chk_hb_exclusive: assert property (!indep[p] && !$past(indep[p])
      |-> !(gh_q && gl_q)) else $error("half-bridge gates both on");
    chk_fet_follow: assert property (indep[p] && !kill
      |=> (gh_q == $past(want_h[p])) && (gl_q == $past(want_l[p])))
      else $error("independent gate does not follow input");
  end

  chk_six_equal_off: assert property ((active_q == SCH_SIX)
    |=> ((high_gate_out | low_gate_out) & $past(hs_s_q ~^ ls_s_q)) == 3'h0)
    else $error("six-input equal levels left a gate on");
  chk_gate_cause: assert property ($rose(high_gate_out[0])
    |-> $past(want_h[0]) && !$past(kill)) else $error("high gate rose without request");
  chk_dead_gap: assert property (!indep[0] && $fell(low_gate_out[0])
    && dead_q >= DT_WIDTH'(8) |-> !high_gate_out[0] [*8])
    else $error("dead time too short");
  chk_fault_pin: assert property ($rose(|flt_s_q)
    |-> ##2 !fault_indicator_n) else $error("fault pin not asserted");
  chk_irq_mask: assert property (irq
    |-> $past(|(status_q & mask_q))) else $error("interrupt without unmasked status");
  chk_scheme_hold: assert property ($changed(active_q)
    |-> $past(all_low)) else $error("scheme changed while inputs active");
  chk_strap_no100: assert property (strap_done_q && !bus_var_q
    |-> active_q != SCH_HB_AB_FC) else $error("strap variant ran scheme 100");
  chk_ready_stall: assert property (!ready_q
    |-> avs_waitrequest) else $error("bus answered before ready");
  chk_bus_answer: assert property ((avs_read || avs_write) && ready_q && avs_waitrequest
    && bus_st_q == BUS_IDLE |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");

  cov_six_high: cover property (active_q == SCH_SIX && high_gate_out[1]);
  cov_fet_both: cover property (low_gate_out[2] && high_gate_out[2]);
  cov_fault_clr: cover property (!fault_indicator_n ##[1:50] fault_indicator_n);
  cov_six_step: cover property (active_q == SCH_ONE && low_gate_out == 3'h7);

endmodule

// ---- gdmd_regs.svh ----
`ifndef GDMD_REGS_SVH
`define GDMD_REGS_SVH

`define GDMD_CLK_PERIOD_NS  10
`define GDMD_READY_TIME_MS  1
`define GDMD_READY_CYCLES   ((`GDMD_READY_TIME_MS * 1000000) / `GDMD_CLK_PERIOD_NS)
`define GDMD_DEAD_TIME_NS   100
`define GDMD_DEAD_CYCLES \
  ((`GDMD_DEAD_TIME_NS + `GDMD_CLK_PERIOD_NS - 1) / `GDMD_CLK_PERIOD_NS)

`define GDMD_OFS_CTRL       5'h00
`define GDMD_OFS_STATUS     5'h04
`define GDMD_OFS_MASK       5'h08
`define GDMD_OFS_DEAD       5'h0C
`define GDMD_OFS_STATE      5'h10

`define GDMD_CTRL_SEL_LSB   0
`define GDMD_CTRL_EN_BIT    4
`define GDMD_STATE_GH_LSB   3
`define GDMD_STATE_GL_LSB   6
`define GDMD_STATE_VAR_BIT  9
`define GDMD_STATE_RDY_BIT  10

`define GDMD_SEL_RST        3'h0
`define GDMD_MASK_RST       10'h000
`define GDMD_KILL_MASK      9'h14F

`endif

// ---- gdmd_pkg.sv ----
package gdmd_pkg;

  localparam int unsigned FAULT_EXT_W = 9;
  localparam int unsigned FAULT_W     = 10;

  typedef enum logic [2:0] {
    SCH_SIX      = 3'h0,
    SCH_THREE    = 3'h1,
    SCH_ONE      = 3'h2,
    SCH_HB_ALL   = 3'h3,
    SCH_HB_AB_FC = 3'h4,
    SCH_HB_BC_FA = 3'h5,
    SCH_HB_A_FBC = 3'h6,
    SCH_FET_ALL  = 3'h7
  } gdmd_scheme_t;

  // Status bit order
  typedef enum int unsigned {
    FLT_SUPPLY_LOW, FLT_PUMP_LOW, FLT_SHORT_SUPPLY, FLT_SHORT_GROUND,
    FLT_OPEN_LOAD, FLT_OVERCURRENT, FLT_GATE_SHORT, FLT_OVERTEMP_WARN,
    FLT_OVERTEMP_SHUT, FLT_MODE_BAD
  } gdmd_fault_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK  = 2'h2
  } gdmd_bus_t;

endpackage

// ---- gdmd_host_model.sv ----
module gdmd_host_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] want_hs,
  input  wire logic [2:0] want_ls,
  input  wire logic       park,
  output logic      [2:0] hs_out,
  output logic      [2:0] ls_out
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge clk) begin
    if (!rst_n || park) begin
      hs_out <= 3'h0;
      ls_out <= 3'h0;
    end else begin
      hs_out <= want_hs;
      ls_out <= want_ls;
    end
  end
endmodule

// ---- tb_top.sv ----
`include "gdmd_regs.svh"
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("[FAIL] %0t %s", $time, msg); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gdmd_pkg::*;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  want_hs = 3'h0;
  logic [2:0]  want_ls = 3'h0;
  logic        park = 1'b1;
  logic [2:0]  hs;
  logic [2:0]  ls;
  logic        variant = 1'b1;
  logic [2:0]  strap = 3'h0;
  logic [8:0]  fault_in = 9'h000;
  logic [2:0]  high_gate_out;
  logic [2:0]  low_gate_out;
  logic        fault_indicator_n;
  logic        irq;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  always #5 clk = ~clk;

  gdmd_top #(.READY_CYCLES(5)) i_dut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_byteenable(4'hF),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .high_side_ctrl_in(hs), .low_side_ctrl_in(ls), .bus_variant_strap(variant),
    .scheme_strap(strap), .fault_in(fault_in), .high_gate_out(high_gate_out),
    .low_gate_out(low_gate_out), .fault_indicator_n(fault_indicator_n), .irq(irq)
  );

  gdmd_host_model i_host (
    .clk(clk), .rst_n(rst_n), .want_hs(want_hs), .want_ls(want_ls), .park(park),
    .hs_out(hs), .ls_out(ls)
  );

  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 200) begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  task automatic drive(input logic [2:0] h, input logic [2:0] l);
    @(posedge clk);
    want_hs <= h;
    want_ls <= l;
    park <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic v, input logic [2:0] s);
    @(posedge clk);
    rst_n <= 1'b0;
    park <= 1'b1;
    variant <= v;
    strap <= s;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic set_scheme(input logic [2:0] s);
    @(posedge clk);
    park <= 1'b1;
    settle(6);
    bus(1'b1, `GDMD_OFS_CTRL, {27'h0, 1'b1, 1'b0, s});
    settle(6);
  endtask

  function automatic logic [5:0] exp_gates(input logic [2:0] s, input logic [2:0] h,
                                           input logic [2:0] l);
    logic [2:0] fet;
    logic [2:0] gh;
    logic [2:0] gl;
    case (s)
      3'h4: fet = 3'h4;
      3'h5: fet = 3'h1;
      3'h6: fet = 3'h6;
      3'h7: fet = 3'h7;
      default: fet = 3'h0;
    endcase
    for (int p = 0; p < 3; p++) begin
      if (fet[p]) begin
        gh[p] = h[p];
        gl[p] = l[p];
      end else if (s == 3'h0) begin
        gh[p] = h[p] & ~l[p];
        gl[p] = l[p] & ~h[p];
      end else begin
        gh[p] = l[p] & h[p];
        gl[p] = l[p] & ~h[p];
      end
    end
    return {gh, gl};
  endfunction

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    logic [2:0] h;
    logic [2:0] l;
    int cnt;
    logic [2:0] sch [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    void'($urandom(50));
    do_reset(1'b1, 3'h0);
    bus(1'b0, `GDMD_OFS_STATE, 32'h0000_0000);
    `CHK(q[10:9], 2'h3, "state ready or variant")
    bus(1'b0, `GDMD_OFS_DEAD, 32'h0000_0000);
    `CHK(q[7:0], 8'h0A, "dead reset")
    bus(1'b0, 5'h14, 32'h0000_0000);
    `CHK(q, 32'h0000_0000, "unmapped read")
    drive(3'h7, 3'h0);
    settle(30);
    `CHK({high_gate_out, low_gate_out}, 6'h00, "gates on while disabled")
    // Every scheme, random inputs, directed inputs for scheme 2
    foreach (sch[i]) begin
      set_scheme(sch[i]);
      bus(1'b0, `GDMD_OFS_STATE, 32'h0000_0000);
      `CHK(q[2:0], sch[i], "scheme not applied")
      for (int k = 0; k < 6 && sch[i] != 3'h2; k++) begin
        h = 3'($urandom());
        l = (k == 0) ? 3'h7 : 3'($urandom());
        h = (k == 0) ? 3'h7 : h;
        drive(h, l);
        settle(30);
        `CHK({high_gate_out, low_gate_out}, exp_gates(sch[i], h, l), "gate map")
      end
      if (sch[i] == 3'h2) begin
        drive(3'h0, 3'h0);
        settle(30);
        `CHK({high_gate_out, low_gate_out}, 6'h07, "six-step brake")
        drive(3'h4, 3'h4);
        settle(30);
        `CHK({high_gate_out, low_gate_out}, 6'h00, "six-step reverse stop")
        drive(3'h3, 3'h5);
        settle(30);
        `CHK({high_gate_out, low_gate_out}, 6'h14, "six-step state one")
      end
    end
    // Dead time on a direct high to low swap
    set_scheme(3'h0);
    bus(1'b1, `GDMD_OFS_DEAD, 32'h0000_0014);
    drive(3'h1, 3'h0);
    settle(30);
    drive(3'h0, 3'h1);
    cnt = 0;
    while (high_gate_out[0] !== 1'b0 && cnt < 50) begin
      settle(1);
      cnt++;
    end
    if (cnt >= 50) begin
      n_mismatch++;
      give_verdict();
    end
    cnt = 0;
    while (low_gate_out[0] !== 1'b1 && cnt < 50) begin
      `CHK(high_gate_out[0] & low_gate_out[0], 1'b0, "shoot through")
      settle(1);
      cnt++;
    end
    if (cnt >= 50) begin
      n_mismatch++;
      give_verdict();
    end
    `CHK(cnt >= 20 && cnt <= 22, 1'b1, "dead time length")
    // Scheme change held off while inputs active
    drive(3'h1, 3'h0);
    bus(1'b1, `GDMD_OFS_CTRL, 32'h0000_0017);
    settle(6);
    bus(1'b0, `GDMD_OFS_STATE, 32'h0000_0000);
    `CHK(q[2:0], 3'h0, "scheme changed under load")
    @(posedge clk);
    park <= 1'b1;
    settle(6);
    bus(1'b0, `GDMD_OFS_STATE, 32'h0000_0000);
    `CHK(q[2:0], 3'h7, "scheme not taken when idle")
    // Each external fault: pin, sticky status, mask, kill
    set_scheme(3'h0);
    drive(3'h7, 3'h0);
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, `GDMD_OFS_MASK, (i % 2 == 0) ? (32'h1 << i) : 32'h0);
      @(posedge clk);
      fault_in <= 9'(1 << i);
      settle(30);
      `CHK(fault_indicator_n, 1'b0, "fault pin high")
      `CHK(irq, (i % 2 == 0), "irq vs mask")
      `CHK(high_gate_out, (`GDMD_KILL_MASK >> i) & 1 ? 3'h0 : 3'h7, "kill")
      @(posedge clk);
      fault_in <= 9'h000;
      settle(4);
      bus(1'b0, `GDMD_OFS_STATUS, 32'h0000_0000);
      `CHK(q[9:0], 10'(1 << i), "status bit")
      bus(1'b1, `GDMD_OFS_STATUS, 32'h1 << i);
      settle(4);
      bus(1'b0, `GDMD_OFS_STATUS, 32'h0000_0000);
      `CHK(q[9:0], 10'h000, "status not cleared")
      `CHK({fault_indicator_n, irq}, 2'h2, "fault outputs after clear")
    end
    // Strap variant refuses scheme 100
    do_reset(1'b0, 3'h4);
    settle(10);
    bus(1'b0, `GDMD_OFS_STATUS, 32'h0000_0000);
    `CHK(q[9], 1'b1, "strap 100 accepted")
    bus(1'b0, `GDMD_OFS_STATE, 32'h0000_0000);
    `CHK(q[9], 1'b0, "variant bit")
    `CHK(fault_indicator_n, 1'b0, "refusal not flagged")
    give_verdict();
  end
endmodule
